// File: voltage_reference_control_defs.vh
`ifndef VOLTAGE_REFERENCE_CONTROL_DEFS_VH
`define VOLTAGE_REFERENCE_CONTROL_DEFS_VH

// =============================================================
// Register map
`define REFCTL_ADDR        8'hd1
`define REFCTL_RESET       8'h00
`define REFCTL_WMASK       8'h3f

// =============================================================
// Field positions
`define REFCTL_BUF_EN_BIT  0
`define REFCTL_BIAS_BIT    1
`define REFCTL_TEMP_BIT    2
`define REFCTL_SRC_BIT     3
`define REFCTL_LVL_BIT     4
`define REFCTL_ZTC_BIT     5

// =============================================================
// Field reset level
`define REFCTL_FIELD_RESET 1'b0

`endif

// File: bias_force_logic.v
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Bias generator request combining
module bias_force_logic (
    input  wire i_sw_bias_on,      // Software forced-on bit
    input  wire i_sw_ztc_on,       // Software zero-tempco forced-on bit
    input  wire i_adc_enabled,     // ADC running
    input  wire i_temp_enabled,    // Temperature sensor running
    input  wire i_osc_enabled,     // Internal oscillator running
    input  wire i_ztc_needed,      // Zero-tempco bias needed by a user
    output wire o_bias_on,         // Bias generator enable
    output wire o_ztc_on           // Zero-tempco bias enable
);

    // Forced on by users or by software
    assign o_bias_on = i_sw_bias_on | i_adc_enabled | i_temp_enabled
                     | i_osc_enabled; // [RQ2] [RQ3]
    assign o_ztc_on  = i_sw_ztc_on | i_ztc_needed; // [RQ7]

endmodule
`default_nettype wire

// File: voltage_reference_control.v
`timescale 1ns/1ps
`default_nettype none
`include "voltage_reference_control_defs.vh"

// Behaviour
// [RQ1] Source bit selects pin or core supply
// [RQ2] Bias forced on by ADC, sensor, oscillator
// [RQ3] Bias bit 0 auto, 1 always on
// [RQ4] Level bit selects 1.5 V or 2.2 V
// [RQ5] Buffer bit drives reference onto pin
// [RQ6] Sensor powered only while its bit set
// [RQ7] Zero-tempco bias auto or forced on
// [RQ8] Reserved upper bits read zero, write zero
// [RQ9] Software clears buffer bit when unused
// [RQ10] Control bits are registered, reset to zero
module voltage_reference_control (
    input  wire       i_clock,          // System clock
    input  wire       i_rstn,           // Synchronous reset, active low
    input  wire [7:0] i_sfr_addr,       // Register address
    input  wire       i_sfr_wr,         // Write strobe
    input  wire       i_sfr_rd,         // Read strobe
    input  wire [7:0] i_sfr_wdata,      // Write data
    input  wire       i_adc_enabled,    // ADC enabled
    input  wire       i_osc_enabled,    // Internal oscillator enabled
    input  wire       i_ztc_needed,     // Zero-tempco bias requested
    output reg  [7:0] o_sfr_rdata,      // Read data
    output wire       o_sfr_sel,        // Address hit
    output wire       o_ref_source_select,     // 1 selects core supply
    output wire       o_ref_level_select,      // 1 selects 2.2 V
    output wire       o_ref_buffer_enable,     // Drive reference pin
    output wire       o_temp_sensor_enable,    // Sensor power
    output wire       o_bias_gen_enable,       // Bias generator on
    output wire       o_zero_tempco_bias_enable // Zero-tempco bias on
);

    // =============================================================
    // Field registers and decode nets
    reg        buf_en_r;
    reg        buf_en_nxt;
    reg        bias_on_r;
    reg        bias_on_nxt;
    reg        temp_on_r;
    reg        temp_on_nxt;
    reg        src_sel_r;
    reg        src_sel_nxt;
    reg        lvl_sel_r;
    reg        lvl_sel_nxt;
    reg        ztc_on_r;
    reg        ztc_on_nxt;
    reg  [7:0] rdata_nxt;
    wire       hit;
    wire       write_hit;
    wire       read_hit;
    wire [7:0] wr_img;
    wire [7:0] ctl_img;

    // =============================================================
    // Register image helpers

    // Keep only the implemented field bits
    function [7:0] implemented_bits;
        input [7:0] value;
        begin
            implemented_bits = value & `REFCTL_WMASK;
        end
    endfunction

    // Pick one field bit out of a byte
    function field_bit;
        input [7:0]   value;
        input integer pos;
        begin
            field_bit = value[pos];
        end
    endfunction

    // Rebuild the register image from the field flops
    function [7:0] pack_fields;
        input buf_en;
        input bias_on;
        input temp_on;
        input src_sel;
        input lvl_sel;
        input ztc_on;
        begin
            pack_fields                     = `REFCTL_RESET;
            pack_fields[`REFCTL_BUF_EN_BIT] = buf_en;
            pack_fields[`REFCTL_BIAS_BIT]   = bias_on;
            pack_fields[`REFCTL_TEMP_BIT]   = temp_on;
            pack_fields[`REFCTL_SRC_BIT]    = src_sel;
            pack_fields[`REFCTL_LVL_BIT]    = lvl_sel;
            pack_fields[`REFCTL_ZTC_BIT]    = ztc_on;
        end
    endfunction

    // =============================================================
    // Address decode

    // Register select and qualified strobes
    assign hit       = (i_sfr_addr == `REFCTL_ADDR);
    assign o_sfr_sel = hit;
    assign write_hit = i_sfr_wr & hit;
    assign read_hit  = i_sfr_rd & hit;

    // Write data with reserved bits dropped
    assign wr_img = implemented_bits(i_sfr_wdata); // [RQ8]

    // =============================================================
    // Write path

    // Next field values, loaded only on a write hit
    always @* begin
        buf_en_nxt  = buf_en_r;
        bias_on_nxt = bias_on_r;
        temp_on_nxt = temp_on_r;
        src_sel_nxt = src_sel_r;
        lvl_sel_nxt = lvl_sel_r;
        ztc_on_nxt  = ztc_on_r;
        if (write_hit) begin
            buf_en_nxt  = field_bit(wr_img, `REFCTL_BUF_EN_BIT);
            bias_on_nxt = field_bit(wr_img, `REFCTL_BIAS_BIT);
            temp_on_nxt = field_bit(wr_img, `REFCTL_TEMP_BIT);
            src_sel_nxt = field_bit(wr_img, `REFCTL_SRC_BIT);
            lvl_sel_nxt = field_bit(wr_img, `REFCTL_LVL_BIT);
            ztc_on_nxt  = field_bit(wr_img, `REFCTL_ZTC_BIT);
        end
    end

    // Reference buffer enable
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            buf_en_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            buf_en_r <= buf_en_nxt; // [RQ5]
        end
    end

    // Bias generator software bit
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            bias_on_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            bias_on_r <= bias_on_nxt; // [RQ3]
        end
    end

    // Temperature sensor power
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            temp_on_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            temp_on_r <= temp_on_nxt; // [RQ6]
        end
    end

    // Reference source select
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            src_sel_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            src_sel_r <= src_sel_nxt; // [RQ1]
        end
    end

    // Internal reference level select
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            lvl_sel_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            lvl_sel_r <= lvl_sel_nxt; // [RQ4]
        end
    end

    // Zero-tempco bias software bit
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            ztc_on_r <= `REFCTL_FIELD_RESET; // [RQ10]
        end else begin
            ztc_on_r <= ztc_on_nxt; // [RQ7]
        end
    end

    // =============================================================
    // Read path

    // Register image as software sees it
    assign ctl_img = pack_fields(buf_en_r, bias_on_r, temp_on_r,
                                 src_sel_r, lvl_sel_r, ztc_on_r);

    // Read data, zero outside a read hit
    always @* begin
        rdata_nxt = `REFCTL_RESET;
        if (read_hit) begin
            rdata_nxt = implemented_bits(ctl_img); // [RQ8]
        end
    end

    // Read data register
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            o_sfr_rdata <= `REFCTL_RESET; // [RQ10]
        end else begin
            o_sfr_rdata <= rdata_nxt;
        end
    end

    // =============================================================
    // Analog control levels

    // Direct field outputs
    assign o_ref_source_select  = src_sel_r; // [RQ1]
    assign o_ref_level_select   = lvl_sel_r; // [RQ4]
    assign o_ref_buffer_enable  = buf_en_r;  // [RQ5]
    assign o_temp_sensor_enable = temp_on_r; // [RQ6]

    // Bias generators: software bit or automatic demand
    bias_force_logic u_bias (
        .i_sw_bias_on   (bias_on_r),       // [RQ3]
        .i_sw_ztc_on    (ztc_on_r),        // [RQ7]
        .i_adc_enabled  (i_adc_enabled),   // [RQ2]
        .i_temp_enabled (temp_on_r),
        .i_osc_enabled  (i_osc_enabled),
        .i_ztc_needed   (i_ztc_needed),
        .o_bias_on      (o_bias_gen_enable),
        .o_ztc_on       (o_zero_tempco_bias_enable)
    );

endmodule
`default_nettype wire

// File: voltage_reference_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module voltage_reference_control_asserts (
    input wire       i_clock, i_rstn, i_sfr_wr, i_sfr_rd, i_ztc_needed,
    input wire       i_adc_enabled, i_osc_enabled, o_sfr_sel,
    input wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
    input wire       o_ref_source_select, o_ref_level_select,
    input wire       o_ref_buffer_enable, o_temp_sensor_enable,
    input wire       o_bias_gen_enable, o_zero_tempco_bias_enable
);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_rstn);
// Write hit and write data
wire       wr = i_sfr_wr && i_sfr_addr == 8'hd1;
wire [7:0] wd = i_sfr_wdata;
// Plain field levels in read order
wire [3:0] fld = {o_ref_level_select, o_ref_source_select,
                  o_temp_sensor_enable, o_ref_buffer_enable};
a_src_follows: assert property (
    wr |=> o_ref_source_select == $past(wd[3]))
    else $error("source bit wrong");
a_bias_forced: assert property (
    (i_adc_enabled || i_osc_enabled || o_temp_sensor_enable)
    |-> o_bias_gen_enable) else $error("bias off");
a_bias_bit: assert property (
    wr && wd[1] |=> o_bias_gen_enable)
    else $error("bias bit ignored");
a_lvl_follows: assert property (
    wr |=> o_ref_level_select == $past(wd[4]))
    else $error("level bit wrong");
a_buf_follows: assert property (
    wr |=> o_ref_buffer_enable == $past(wd[0]))
    else $error("buffer bit wrong");
a_temp_follows: assert property (
    wr |=> o_temp_sensor_enable == $past(wd[2]))
    else $error("sensor bit wrong");
a_ztc_forced: assert property (
    wr && wd[5] |=> o_zero_tempco_bias_enable)
    else $error("zero tempco off");
a_ztc_needed: assert property (
    i_ztc_needed |-> o_zero_tempco_bias_enable)
    else $error("zero tempco not on demand");
a_rsvd_zero: assert property (
    i_sfr_rd && o_sfr_sel |=> !o_sfr_rdata[7:6])
    else $error("reserved bits set");
a_read_back: assert property (
    i_sfr_rd && o_sfr_sel |=>
    {o_sfr_rdata[4:2], o_sfr_rdata[0]} == $past(fld))
    else $error("read data wrong");
a_hold_bits: assert property (
    !wr |=> $stable(fld))
    else $error("control bit moved");
c_write: cover property (wr);
c_read: cover property (i_sfr_rd && o_sfr_sel);
c_adc: cover property (i_adc_enabled && !o_temp_sensor_enable);
c_ztc: cover property (i_ztc_needed);
endmodule
bind voltage_reference_control voltage_reference_control_asserts i_chk (
    .i_clock                   (i_clock),
    .i_rstn                    (i_rstn),
    .i_sfr_wr                  (i_sfr_wr),
    .i_sfr_rd                  (i_sfr_rd),
    .i_ztc_needed              (i_ztc_needed),
    .i_adc_enabled             (i_adc_enabled),
    .i_osc_enabled             (i_osc_enabled),
    .o_sfr_sel                 (o_sfr_sel),
    .i_sfr_addr                (i_sfr_addr),
    .i_sfr_wdata               (i_sfr_wdata),
    .o_sfr_rdata               (o_sfr_rdata),
    .o_ref_source_select       (o_ref_source_select),
    .o_ref_level_select        (o_ref_level_select),
    .o_ref_buffer_enable       (o_ref_buffer_enable),
    .o_temp_sensor_enable      (o_temp_sensor_enable),
    .o_bias_gen_enable         (o_bias_gen_enable),
    .o_zero_tempco_bias_enable (o_zero_tempco_bias_enable)
);
`default_nettype wire

// File: tb_voltage_reference_control.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb_voltage_reference_control;
localparam integer MAX_CYCLES = 500;
reg        clk = 0, rstn = 0, wr = 0, rd = 0, adc = 0, osc = 0, ztc = 0;
reg  [7:0] a = 0, d = 0, v;
wire [7:0] q;
wire [5:0] o;
wire       sel;
integer    n_errors = 0, n_tests = 0, cyc = 0;
voltage_reference_control i_voltage_reference_control (.i_clock(clk),
    .i_rstn(rstn), .i_sfr_addr(a), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(d), .i_adc_enabled(adc), .i_osc_enabled(osc),
    .i_ztc_needed(ztc), .o_sfr_rdata(q), .o_sfr_sel(sel),
    .o_ref_source_select(o[3]), .o_ref_level_select(o[4]),
    .o_ref_buffer_enable(o[0]), .o_temp_sensor_enable(o[2]),
    .o_bias_gen_enable(o[1]), .o_zero_tempco_bias_enable(o[5]));
// Clock and hang guard
initial forever #5 clk = ~clk;
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == MAX_CYCLES) begin
        n_errors = n_errors + 1;
        print_verdict;
    end
end
task chk(input [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
        n_errors++;
        $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
endtask
task wrt(input [7:0] ad, dt);
    @(negedge clk);
    a = ad;
    d = dt;
    wr = 1;
    @(negedge clk);
    wr = 0;
endtask
task rdr(input [7:0] ad);
    @(negedge clk);
    a = ad;
    rd = 1;
    @(negedge clk);
    rd = 0;
    v = q;
endtask
task t_fields;
    rdr(8'hd1);
    chk(v, 8'h00);
    chk({2'h0, o}, 8'h00);
    chk({7'h00, sel}, 8'h01);
    wrt(8'hd1, 8'h01);
    chk({2'h0, o}, 8'h01);
    wrt(8'hd1, 8'h02);
    chk({2'h0, o}, 8'h02);
    wrt(8'hd1, 8'h04);
    chk({2'h0, o}, 8'h06);
    wrt(8'hd1, 8'h08);
    chk({2'h0, o}, 8'h08);
    wrt(8'hd1, 8'h10);
    chk({2'h0, o}, 8'h10);
    wrt(8'hd1, 8'h20);
    chk({2'h0, o}, 8'h20);
    wrt(8'hd1, 8'h2a);
    rdr(8'hd1);
    chk(v, 8'h2a);
    wrt(8'hd1, 8'h3f);
    rdr(8'hd1);
    chk(v, 8'h3f);
    wrt(8'hd0, 8'h00);
    rdr(8'hd0);
    chk(v, 8'h00);
    chk({7'h00, sel}, 8'h00);
    chk({2'h0, o}, 8'h3f);
    $display("field test done");
endtask
task t_force;
    wrt(8'hd1, 8'h00);
    adc = 1;
    @(negedge clk);
    chk({2'h0, o}, 8'h02);
    adc = 0;
    osc = 1;
    @(negedge clk);
    chk({2'h0, o}, 8'h02);
    osc = 0;
    ztc = 1;
    @(negedge clk);
    chk({2'h0, o}, 8'h20);
    ztc = 0;
    @(negedge clk);
    chk({2'h0, o}, 8'h00);
    $display("force test done");
endtask
task t_reset;
    wrt(8'hd1, 8'h3f);
    rstn = 0;
    repeat (2) @(negedge clk);
    chk({2'h0, o}, 8'h00);
    rstn = 1;
    rdr(8'hd1);
    chk(v, 8'h00);
    $display("reset test done");
endtask
task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// Main sequence
initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    t_fields;
    t_force;
    t_reset;
    print_verdict;
end
endmodule
`default_nettype wire
